// >>> rtl/timer_pwm_unit.sv
// Two-channel timer/PWM unit with a byte-wide register port.
// Assumes all inputs synchronous to mclk; interrupt lines go to a
// controller outside.
// What this block does
// RL1 - Two channels: capture, compare or PWM
// RL2 - Capture on rising, falling or either edge
// RL3 - Compare match sets, clears or toggles pin
// RL4 - PWM output polarity selectable
// RL5 - One bit puts all channels center-aligned
// RL6 - 16-bit counter, up or up/down
// RL7 - 16-bit modulus bounds counter period
// RL8 - Clock: bus, fixed system, external pin
// RL9 - Prescaler divides by 1 to 128
// RL10 - Fixed clock no faster than main/4
// RL11 - One irq per channel plus overflow irq
// RL12 - Counter byte write clears counter, prescaler
// RL13 - Halted counter read returns live value
// RL14 - Halted control/counter write resets counter latch
// RL15 - Halted value read returns actual register
// RL16 - Halted channel control write resets latch
// RL17 - No value writes in input capture
// RL18 - Compare value loads at next counter step
// RL19 - PWM value loads at modulus-1 to modulus
// RL20 - Center PWM value equal modulus: 100%
// RL21 - Source zero stops; bytes kept coherent
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_unit (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Software byte port
    input wire timer_pwm_pkg::byte_access_type acc,
    output logic [7:0] rdata,
    // Debug halt
    input wire logic debug_halt_mode,
    // Counter clock inputs
    input wire logic external_timer_clock_pin,
    // Channel pins
    input wire logic [1:0] ch_pin_in,
    output logic [1:0] ch_pin_out,
    // Interrupts
    output timer_pwm_pkg::irq_bundle_type irqs
);
    localparam int nch = timer_pwm_pkg::num_channels;

    logic [7:0] tsc_r;
    logic [15:0] count_r, modulus_r;
    logic [7:0] mod_hold_r;
    logic mod_half_r;
    logic down_r;
    logic [6:0] presc_r;
    logic [1:0] fixdiv_r;
    logic ext_prev_r;
    logic src_tick, step, running;
    logic [7:0] cnt_latch_r;
    logic cnt_latched_r;
    logic [7:0] csc_r [nch];
    logic [15:0] wbuf_r [nch];
    logic [nch-1:0] whalf_r, commit_r, vlatched_r, ev;
    logic [7:0] vlatch_r [nch];
    logic [15:0] value [nch];
    logic [1:0] ch_pins_r;
    logic [7:0] rdata_nxt;
    logic ovf_event;
    logic [2:0] psel;

    // Channel index of a select, or nch when none
    function automatic int ch_of(input logic [3:0] sel);
        int k;
        k = nch;
        for (int i = 0; i < nch; i++) begin
            if (sel >= timer_pwm_pkg::sel_ch0_status_control +
                4'(i) * timer_pwm_pkg::sel_ch_stride &&
                sel < timer_pwm_pkg::sel_ch0_status_control +
                4'(i + 1) * timer_pwm_pkg::sel_ch_stride) begin
                k = i;
            end
        end
        return k;
    endfunction : ch_of

    function automatic logic [1:0] part_of(input logic [3:0] sel);
        logic [3:0] off;
        off = 4'(sel - timer_pwm_pkg::sel_ch0_status_control);
        return 2'(off % timer_pwm_pkg::sel_ch_stride);
    endfunction : part_of

    logic wr_count;
    assign wr_count = acc.wr && (acc.sel == timer_pwm_pkg::sel_count_high ||
        acc.sel == timer_pwm_pkg::sel_count_low);
    assign psel = tsc_r[timer_pwm_pkg::tsc_prescale_hi:
        timer_pwm_pkg::tsc_prescale_lo];

    // Source tick selection; halt freezes the counter
    always_comb begin
        unique case (tsc_r[timer_pwm_pkg::tsc_clock_source_hi:
            timer_pwm_pkg::tsc_clock_source_lo]) // RL8
            timer_pwm_pkg::clk_bus: src_tick = 1'b1;
            timer_pwm_pkg::clk_fixed:
                src_tick = (fixdiv_r == timer_pwm_pkg::fixed_div_last); // RL10
            timer_pwm_pkg::clk_external:
                src_tick = external_timer_clock_pin && !ext_prev_r;
            default: src_tick = 1'b0; // RL21
        endcase
        if (debug_halt_mode) begin
            src_tick = 1'b0;
        end
    end
    assign running = tsc_r[timer_pwm_pkg::tsc_clock_source_hi:
        timer_pwm_pkg::tsc_clock_source_lo] != timer_pwm_pkg::clk_stopped;
    assign step = src_tick && !wr_count &&
        (psel == 3'h0 || presc_r == 7'((8'h01 << psel) - 8'h01)); // RL9

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fixdiv_r <= 2'h0;
            ext_prev_r <= 1'b0;
        end else begin
            fixdiv_r <= fixdiv_r + 2'h1;
            ext_prev_r <= external_timer_clock_pin;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            presc_r <= 7'h00;
        end else if (wr_count) begin
            presc_r <= 7'h00; // RL12
        end else if (src_tick) begin
            presc_r <= step ? 7'h00 : presc_r + 7'h01;
        end
    end

    // Counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_r <= 16'h0000;
            down_r <= 1'b0;
        end else if (wr_count) begin
            count_r <= 16'h0000; // RL12
            down_r <= 1'b0;
        end else if (step) begin
            if (tsc_r[timer_pwm_pkg::tsc_center_aligned]) begin // RL6
                if (!down_r && count_r >= modulus_r) begin
                    down_r <= 1'b1;
                    count_r <= count_r - 16'h0001;
                end else if (down_r && count_r <= 16'h0001) begin
                    down_r <= 1'b0;
                    count_r <= 16'h0000;
                end else begin
                    count_r <= down_r ? count_r - 16'h0001 : count_r + 16'h0001;
                end
            end else begin
                down_r <= 1'b0;
                if (modulus_r != 16'h0000 && count_r >= modulus_r) begin // RL7
                    count_r <= 16'h0000;
                end else begin
                    count_r <= count_r + 16'h0001;
                end
            end
        end
    end

    assign ovf_event = step && (tsc_r[timer_pwm_pkg::tsc_center_aligned] ?
        (!down_r && count_r >= modulus_r) :
        (count_r == ((modulus_r == 16'h0000) ? timer_pwm_pkg::count_full :
        modulus_r)));

    // Timer status/control; overflow flag set wins over clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tsc_r <= timer_pwm_pkg::tsc_reset;
        end else begin
            if (acc.wr && acc.sel == timer_pwm_pkg::sel_status_control) begin
                tsc_r[6:0] <= acc.wdata[6:0];
                if (!acc.wdata[timer_pwm_pkg::tsc_overflow_flag]) begin
                    tsc_r[timer_pwm_pkg::tsc_overflow_flag] <= 1'b0;
                end
            end
            if (ovf_event) begin
                tsc_r[timer_pwm_pkg::tsc_overflow_flag] <= 1'b1; // RL11
            end
        end
    end

    // Modulus, written high then low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modulus_r <= timer_pwm_pkg::modulus_reset;
            mod_hold_r <= 8'h00;
            mod_half_r <= 1'b0;
        end else if (acc.wr && acc.sel == timer_pwm_pkg::sel_modulus_high) begin
            mod_hold_r <= acc.wdata;
            mod_half_r <= 1'b1;
        end else if (acc.wr && acc.sel == timer_pwm_pkg::sel_modulus_low) begin
            modulus_r <= {mod_half_r ? mod_hold_r : modulus_r[15:8], acc.wdata};
            mod_half_r <= 1'b0;
        end else if (debug_halt_mode && acc.wr &&
            acc.sel == timer_pwm_pkg::sel_status_control) begin
            mod_half_r <= 1'b0;
        end
    end

    // Counter read coherency latch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_latched_r <= 1'b0;
            cnt_latch_r <= 8'h00;
        end else if (debug_halt_mode && acc.wr &&
            (wr_count || acc.sel == timer_pwm_pkg::sel_status_control)) begin
            cnt_latched_r <= 1'b0; // RL14
        end else if (acc.rd && acc.sel == timer_pwm_pkg::sel_count_high &&
            !debug_halt_mode) begin
            cnt_latched_r <= 1'b1; // RL21
            cnt_latch_r <= count_r[7:0];
        end else if (acc.rd && acc.sel == timer_pwm_pkg::sel_count_low) begin
            cnt_latched_r <= 1'b0;
        end
    end

    // Channel registers
    generate
        for (genvar c = 0; c < nch; c++) begin : g_ch
            logic sel_here;
            logic capture_mode;
            assign sel_here = ch_of(acc.sel) == c;
            assign capture_mode = !tsc_r[timer_pwm_pkg::tsc_center_aligned] &&
                csc_r[c][timer_pwm_pkg::csc_mode_b:
                timer_pwm_pkg::csc_mode_a] == 2'h0;

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    csc_r[c] <= timer_pwm_pkg::csc_reset;
                end else begin
                    if (acc.wr && sel_here && part_of(acc.sel) == 2'h0) begin
                        csc_r[c][6:0] <= acc.wdata[6:0];
                        if (!acc.wdata[timer_pwm_pkg::csc_flag]) begin
                            csc_r[c][timer_pwm_pkg::csc_flag] <= 1'b0;
                        end
                    end
                    if (ev[c]) begin
                        csc_r[c][timer_pwm_pkg::csc_flag] <= 1'b1; // RL11
                    end
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    wbuf_r[c] <= timer_pwm_pkg::value_reset;
                    whalf_r[c] <= 1'b0;
                    commit_r[c] <= 1'b0;
                end else begin
                    commit_r[c] <= 1'b0;
                    if (acc.wr && sel_here && !capture_mode) begin // RL17
                        if (part_of(acc.sel) == 2'h1) begin
                            wbuf_r[c][15:8] <= acc.wdata;
                            whalf_r[c] <= 1'b1;
                        end else if (part_of(acc.sel) == 2'h2) begin
                            wbuf_r[c][7:0] <= acc.wdata;
                            whalf_r[c] <= 1'b0;
                            commit_r[c] <= whalf_r[c];
                        end
                    end
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    vlatched_r[c] <= 1'b0;
                    vlatch_r[c] <= 8'h00;
                end else if (debug_halt_mode && acc.wr && sel_here &&
                    part_of(acc.sel) == 2'h0) begin
                    vlatched_r[c] <= 1'b0; // RL16
                end else if (acc.rd && sel_here && !debug_halt_mode &&
                    part_of(acc.sel) == 2'h1) begin
                    vlatched_r[c] <= 1'b1;
                    vlatch_r[c] <= value[c][7:0];
                end else if (acc.rd && sel_here && part_of(acc.sel) == 2'h2) begin
                    vlatched_r[c] <= 1'b0;
                end
            end

            timer_channel u_ch (
                .mclk(mclk),
                .rst(rst),
                .count(count_r),
                .modulus(modulus_r),
                .count_step(step),
                .count_down(down_r),
                .clock_running(running),
                .center_aligned(tsc_r[timer_pwm_pkg::tsc_center_aligned]),
                .control(csc_r[c]),
                .value_commit(commit_r[c]),
                .value_wbuf(wbuf_r[c]),
                .pin_in(ch_pin_in[c]),
                .pin_out(ch_pins_r[c]),
                .value(value[c]),
                .event_pulse(ev[c])
            );
        end
    endgenerate

    // Read mux; halted reads show live values
    always_comb begin
        int k;
        k = ch_of(acc.sel);
        rdata_nxt = 8'h00;
        if (k < nch) begin
            unique case (part_of(acc.sel))
                2'h0: rdata_nxt = csc_r[k];
                2'h1: rdata_nxt = value[k][15:8];
                default: rdata_nxt = (vlatched_r[k] && !debug_halt_mode) ?
                    vlatch_r[k] : value[k][7:0]; // RL15
            endcase
        end else begin
            unique case (acc.sel)
                timer_pwm_pkg::sel_status_control: rdata_nxt = tsc_r;
                timer_pwm_pkg::sel_count_high: rdata_nxt = count_r[15:8];
                timer_pwm_pkg::sel_count_low:
                    rdata_nxt = (cnt_latched_r && !debug_halt_mode) ?
                        cnt_latch_r : count_r[7:0]; // RL13
                timer_pwm_pkg::sel_modulus_high: rdata_nxt = modulus_r[15:8];
                timer_pwm_pkg::sel_modulus_low: rdata_nxt = modulus_r[7:0];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            ch_pin_out <= 2'h0;
            irqs <= '0;
        end else begin
            rdata <= acc.rd ? rdata_nxt : rdata;
            ch_pin_out <= ch_pins_r;
            irqs.overflow_irq <= tsc_r[timer_pwm_pkg::tsc_overflow_flag] &&
                tsc_r[timer_pwm_pkg::tsc_overflow_ie]; // RL11
            for (int i = 0; i < nch; i++) begin
                irqs.irq[i] <= csc_r[i][timer_pwm_pkg::csc_flag] &&
                    csc_r[i][timer_pwm_pkg::csc_ie];
            end
        end
    end

endmodule : timer_pwm_unit
`default_nettype wire

// >>> rtl/timer_pwm_pkg.sv
// Package for the two-channel timer/PWM unit: register selects, field
// layouts, reset values and the channel mode, byte access and interrupt carrier types.
// Assumes a byte-wide software port and one 100 MHz clock.
package timer_pwm_pkg;

    localparam int num_channels = 2;
    localparam int count_width = 16;

    // Byte register selects on the software port
    localparam logic [3:0] sel_status_control = 4'h0;
    localparam logic [3:0] sel_count_high = 4'h1;
    localparam logic [3:0] sel_count_low = 4'h2;
    localparam logic [3:0] sel_modulus_high = 4'h3;
    localparam logic [3:0] sel_modulus_low = 4'h4;
    localparam logic [3:0] sel_ch0_status_control = 4'h5;
    localparam logic [3:0] sel_ch0_value_high = 4'h6;
    localparam logic [3:0] sel_ch0_value_low = 4'h7;
    localparam logic [3:0] sel_ch_stride = 4'h3;

    // Timer status/control fields
    localparam int tsc_overflow_flag = 7;
    localparam int tsc_overflow_ie = 6;
    localparam int tsc_center_aligned = 5;
    localparam int tsc_clock_source_hi = 4;
    localparam int tsc_clock_source_lo = 3;
    localparam int tsc_prescale_hi = 2;
    localparam int tsc_prescale_lo = 0;

    // Channel status/control fields
    localparam int csc_flag = 7;
    localparam int csc_ie = 6;
    localparam int csc_mode_b = 5;
    localparam int csc_mode_a = 4;
    localparam int csc_edge_b = 3;
    localparam int csc_edge_a = 2;

    // Clock source encodings
    localparam logic [1:0] clk_stopped = 2'h0;
    localparam logic [1:0] clk_bus = 2'h1;
    localparam logic [1:0] clk_fixed = 2'h2;
    localparam logic [1:0] clk_external = 2'h3;

    localparam logic [7:0] tsc_reset = 8'h00;
    localparam logic [7:0] csc_reset = 8'h00;
    localparam logic [15:0] modulus_reset = 16'h0000;
    localparam logic [15:0] value_reset = 16'h0000;
    localparam logic [15:0] count_full = 16'hffff;

    // Fixed system clock is main clock / 4 at most
    localparam int fixed_clock_divide = 4;
    localparam logic [1:0] fixed_div_last = 2'(fixed_clock_divide - 1);

    typedef enum logic [3:0] {
        mode_capture = 4'b0001,
        mode_compare = 4'b0010,
        mode_edge_pwm = 4'b0100,
        mode_center_pwm = 4'b1000
    } ch_mode_type;

    // Software byte access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] sel;
        logic [7:0] wdata;
    } byte_access_type;

    // Per-channel and overflow interrupts seen from outside
    typedef struct packed {
        logic [num_channels-1:0] irq;
        logic overflow_irq;
    } irq_bundle_type;

endpackage : timer_pwm_pkg

// >>> rtl/timer_channel.sv
// One capture/compare/PWM channel of the timer unit.
// Assumes count and modulus come from the shared counter, and that its
// pin input is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module timer_channel (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Shared counter
    input wire logic [15:0] count,
    input wire logic [15:0] modulus,
    input wire logic count_step,
    input wire logic count_down,
    input wire logic clock_running,
    input wire logic center_aligned,
    // Control byte and value write
    input wire logic [7:0] control,
    input wire logic value_commit,
    input wire logic [15:0] value_wbuf,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    // State
    output logic [15:0] value,
    output logic event_pulse
);
    timer_pwm_pkg::ch_mode_type mode;
    logic [1:0] edge_sel;
    logic pin_prev_r;
    logic rise, fall, hit;
    logic pending_r;
    logic [15:0] value_r;
    logic out_r;

    always_comb begin
        edge_sel = control[timer_pwm_pkg::csc_edge_b:timer_pwm_pkg::csc_edge_a];
        if (center_aligned) begin // RL5
            mode = timer_pwm_pkg::mode_center_pwm;
        end else if (control[timer_pwm_pkg::csc_mode_b]) begin
            mode = timer_pwm_pkg::mode_edge_pwm;
        end else if (control[timer_pwm_pkg::csc_mode_a]) begin
            mode = timer_pwm_pkg::mode_compare;
        end else begin
            mode = timer_pwm_pkg::mode_capture; // RL1
        end
    end

    assign rise = pin_in && !pin_prev_r;
    assign fall = !pin_in && pin_prev_r;
    assign hit = count_step && (count == value_r);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_in;
        end
    end

    // Buffered value load
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending_r <= 1'b0;
        end else if (value_commit && clock_running &&
            mode != timer_pwm_pkg::mode_capture) begin
            pending_r <= 1'b1;
        end else if (count_step && (mode == timer_pwm_pkg::mode_compare ||
            (!count_down && count == modulus - 16'h0001))) begin
            pending_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            value_r <= timer_pwm_pkg::value_reset;
        end else begin
            unique case (mode)
                timer_pwm_pkg::mode_capture: begin
                    if (clock_running && ((edge_sel[0] && rise) ||
                        (edge_sel[1] && fall))) begin // RL2
                        value_r <= count;
                    end
                end
                timer_pwm_pkg::mode_compare: begin
                    if (!clock_running && value_commit) begin
                        value_r <= value_wbuf;
                    end else if (pending_r && count_step) begin // RL18
                        value_r <= value_wbuf;
                    end
                end
                timer_pwm_pkg::mode_edge_pwm,
                timer_pwm_pkg::mode_center_pwm: begin
                    if (!clock_running && value_commit) begin
                        value_r <= value_wbuf;
                    end else if (pending_r && count_step && !count_down &&
                        count == modulus - 16'h0001) begin // RL19
                        value_r <= value_wbuf;
                    end
                end
            endcase
        end
    end

    // Events for the channel flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            event_pulse <= 1'b0;
        end else begin
            unique case (mode)
                timer_pwm_pkg::mode_capture:
                    event_pulse <= clock_running && ((edge_sel[0] && rise) ||
                        (edge_sel[1] && fall));
                default:
                    event_pulse <= hit;
            endcase
        end
    end

    // Output pin
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_r <= 1'b0;
        end else begin
            unique case (mode)
                timer_pwm_pkg::mode_capture: out_r <= 1'b0;
                timer_pwm_pkg::mode_compare: begin
                    if (hit) begin // RL3
                        unique case (edge_sel)
                            2'h1: out_r <= !out_r;
                            2'h2: out_r <= 1'b0;
                            2'h3: out_r <= 1'b1;
                            default: out_r <= out_r;
                        endcase
                    end
                end
                timer_pwm_pkg::mode_edge_pwm: begin
                    // High-true when edge_sel[1] set, else low-true
                    out_r <= (count < value_r) ^ !edge_sel[1]; // RL4
                end
                timer_pwm_pkg::mode_center_pwm: begin
                    out_r <= ((count < value_r) ||
                        (value_r == modulus)) ^ !edge_sel[1]; // RL20 RL4
                end
            endcase
        end
    end

    assign pin_out = out_r;
    assign value = value_r;

endmodule : timer_channel
`default_nettype wire

// >>> bench/timer_pwm_props.sv
// Checker for the timer/PWM unit top ports.
// Assumes one mclk domain and async active-high rst.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Byte port
    input wire timer_pwm_pkg::byte_access_type acc,
    input wire logic [7:0] rdata,
    // Pins and status
    input wire logic debug_halt_mode,
    input wire logic [1:0] ch_pin_out,
    input wire timer_pwm_pkg::irq_bundle_type irqs
);
    sequence s_rd_lo;
        debug_halt_mode && acc.rd && acc.sel == 4'h2;
    endsequence
    sequence s_clr;
        debug_halt_mode && acc.wr && acc.sel inside {4'h1, 4'h2};
    endsequence
    chk_rdata_hold: assert property (@(posedge mclk) disable iff (rst)
        !acc.rd |=> $stable(rdata)) else $error("rdata moved");
    chk_unmapped_zero: assert property (@(posedge mclk) disable iff (rst)
        acc.rd && acc.sel > 4'ha |=> rdata == 8'h00) else $error("unmapped");
    chk_count_clear: assert property (@(posedge mclk) disable iff (rst)
        s_clr ##2 s_rd_lo |=> rdata == 8'h00) else $error("count kept");
    chk_halt_frozen: assert property (@(posedge mclk) disable iff (rst)
        s_rd_lo ##2 s_rd_lo |=> rdata == $past(rdata, 2))
        else $error("count moved in halt");
    chk_reset_quiet: assert property (@(posedge mclk)
        rst |=> ch_pin_out == 2'h0 && irqs == '0) else $error("reset out");
    chk_ovf_irq_off: assert property (@(posedge mclk) disable iff (rst)
        acc.wr && acc.sel == 4'h0 && !acc.wdata[6] |-> ##3 !irqs.overflow_irq)
        else $error("overflow irq stuck");
    chk_ch_irq_off: assert property (@(posedge mclk) disable iff (rst)
        acc.wr && acc.sel == 4'h8 && !acc.wdata[6] |-> ##3 !irqs.irq[1])
        else $error("channel irq stuck");
    chk_pins_frozen: assert property (@(posedge mclk) disable iff (rst)
        (debug_halt_mode && !acc.wr)[*6] |-> $stable(ch_pin_out))
        else $error("pin moved in halt");
endmodule : timer_pwm_props
bind timer_pwm_unit timer_pwm_props u_props (.mclk(mclk), .rst(rst),
    .acc(acc), .rdata(rdata), .debug_halt_mode(debug_halt_mode),
    .ch_pin_out(ch_pin_out), .irqs(irqs));
`default_nettype wire

// >>> bench/pin_partner.sv
// Far-side pin source: drives the capture inputs as commanded.
// Assumes the bench sets level at mclk edges.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] level,
    output logic [1:0] pin_in
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) pin_in <= 2'h0;
        else pin_in <= level;
    end
endmodule : pin_partner
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the timer/PWM unit.
// Assumes the checker bind and the pin partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic halt = 1'b0;
    logic [1:0] level = 2'h0;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [7:0] rdata;
    timer_pwm_pkg::byte_access_type acc = '0;
    timer_pwm_pkg::irq_bundle_type irqs;
    int fail_count = 0;
    int n_compared = 0;
    logic [15:0] v;
    logic [15:0] w;
    int h;
    always #5 mclk = ~mclk;
    timer_pwm_unit dut (.mclk(mclk), .rst(rst), .acc(acc), .rdata(rdata),
        .debug_halt_mode(halt), .external_timer_clock_pin(1'b0),
        .ch_pin_in(pin_in), .ch_pin_out(pin_out), .irqs(irqs));
    pin_partner far (.mclk(mclk), .rst(rst), .level(level), .pin_in(pin_in));
    task automatic check(input string what, input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic wr(input logic [3:0] sel, input logic [7:0] d);
        @(posedge mclk);
        acc <= '{1'b1, 1'b0, sel, d};
        @(posedge mclk);
        acc <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] sel, output logic [15:0] d);
        @(posedge mclk);
        acc <= '{1'b0, 1'b1, sel, 8'h00};
        @(posedge mclk);
        acc <= '0;
        #1 d = {8'h00, rdata};
    endtask : rd
    task automatic rd16(input logic [3:0] sel, output logic [15:0] d);
        logic [15:0] lo;
        rd(sel, d);
        rd(sel + 4'h1, lo);
        d = {d[7:0], lo[7:0]};
    endtask : rd16
    task automatic highs(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge mclk);
            #1 c += (pin_out[0] === 1'b1);
        end
    endtask : highs
    task automatic t_halt;
        wr(4'h0, 8'h08);
        repeat (30) @(posedge mclk);
        halt <= 1'b1;
        wr(4'h2, 8'h55);
        rd(4'h2, v);
        check("count", v, 16'h0000);
        rd(4'h2, w);
        check("frozen", w, v);
        rd(4'hf, v);
        check("unmapped", v, 16'h0000);
        halt <= 1'b0;
        $display("halt test done");
    endtask : t_halt
    task automatic t_value;
        wr(4'h0, 8'h00);
        wr(4'h5, 8'h10);
        wr(4'h6, 8'h12);
        wr(4'h7, 8'h34);
        rd16(4'h6, v);
        check("value", v, 16'h1234);
        wr(4'h0, 8'h08);
        wr(4'h6, 8'h43);
        wr(4'h7, 8'h21);
        @(posedge mclk);
        rd16(4'h6, v);
        check("compare load", v, 16'h4321);
        wr(4'h5, 8'h00);
        wr(4'h6, 8'h56);
        wr(4'h7, 8'h78);
        halt <= 1'b1;
        rd16(4'h6, v);
        check("capture value", v, 16'h4321);
        halt <= 1'b0;
        $display("value test done");
    endtask : t_value
    task automatic t_pwm;
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h10);
        wr(4'h5, 8'h28);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h08);
        wr(4'h0, 8'h48);
        repeat (40) @(posedge mclk);
        highs(17, h);
        check("high true", 16'(h), 16'h0008);
        check("ovf irq", 16'(irqs.overflow_irq), 16'h0001);
        wr(4'h0, 8'h08);
        wr(4'h5, 8'h20);
        repeat (20) @(posedge mclk);
        check("ovf off", 16'(irqs.overflow_irq), 16'h0000);
        highs(17, h);
        check("low true", 16'(h), 16'h0009);
        wr(4'h5, 8'h28);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h10);
        wr(4'h0, 8'h28);
        repeat (80) @(posedge mclk);
        highs(32, h);
        check("full duty", 16'(h), 16'h0020);
        $display("pwm test done");
    endtask : t_pwm
    task automatic t_capture;
        wr(4'h0, 8'h08);
        wr(4'h8, 8'h44);
        level <= 2'h2;
        h = 0;
        while (irqs.irq[1] !== 1'b1 && h < 20) begin
            @(posedge mclk);
            h++;
        end
        if (h == 20) begin
            fail_count++;
            conclude;
        end
        check("rise irq", 16'(irqs.irq[1]), 16'h0001);
        wr(4'h8, 8'h84);
        wr(4'h8, 8'h44);
        @(posedge mclk);
        level <= 2'h0;
        repeat (8) @(posedge mclk);
        check("fall ignored", 16'(irqs.irq[1]), 16'h0000);
        $display("capture test done");
    endtask : t_capture
    task automatic conclude;
        $display("compared %0d wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_halt;
        t_value;
        t_pwm;
        t_capture;
        conclude;
    end
endmodule : tb
`default_nettype wire
